// ---- rtl/flash_seq_defines.svh ----
// Constants for the serial flash program/erase/suspend sequencer.
// Assumes a 20 MHz system clock; times are given in ns and converted to cycles with CYCLES_UP.
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CLK_PERIOD_NS           50
`define PAGE_PROGRAM_TIME_NS    400000
`define SUBSECTOR_ERASE_TIME_NS 50000000
`define SECTOR_ERASE_TIME_NS    150000000
`define BULK_ERASE_TIME_NS      1000000000
`define SUSPEND_LATENCY_NS      30000
`define CYCLES_UP(ns)           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_LATENCY_CYCLES  16'(`CYCLES_UP(`SUSPEND_LATENCY_NS))

`define OPC_WRITE_ENABLE        8'h06
`define OPC_WRITE_DISABLE       8'h04
`define OPC_ENTER_ADDR4         8'hb7
`define OPC_EXIT_ADDR4          8'he9
`define OPC_CLEAR_FLAGS         8'h50
`define OPC_PAGE_PROGRAM        8'h02
`define OPC_QUAD_PROGRAM        8'h32
`define OPC_QUAD_PROGRAM_A4     8'h34
`define OPC_SUBSECTOR_ERASE     8'h20
`define OPC_SUBSECTOR_ERASE_ALT 8'h52
`define OPC_SECTOR_ERASE        8'hd8
`define OPC_BULK_ERASE          8'hc7
`define OPC_BULK_ERASE_ALT      8'h60
`define OPC_SUSPEND             8'h75
`define OPC_RESUME              8'h7a

`define FS_READY      7
`define FS_ERASE_SUSP 6
`define FS_ERASE_ERR  5
`define FS_PROG_ERR   4
`define FS_PROG_SUSP  2
`define FS_PROT_ERR   1
`define FS_ADDR4      0
`define FS_RESET      8'h80

`define REG_CONFIG      12'h000
`define REG_PROTECT     12'h004
`define REG_ERASE_LIMIT 12'h008
`define REG_STATUS      12'h00c
`define REG_ARRAY_PAGE  4'h1
`define ERASE_LIMIT_RST 32'hffffffff
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define ADDR_BYTES_3    3'h3
`define ADDR_BYTES_4    3'h4

`endif

// ---- rtl/flash_seq_pkg.sv ----
// Types for the serial flash sequencer: link phases, engine states, state record.
// Assumes flash_seq_defines.svh constants are used alongside.
package flash_seq_pkg;

	typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} phase_type;
	typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_SUSPENDING} eng_type;
	typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE_SUB, OP_ERASE_SEC, OP_ERASE_BULK} op_type;

	typedef struct packed {
		logic cs1, cs2, cs3, sclk1, sclk2, sclk3;
		logic [3:0] io1, io2;
		phase_type phase;
		logic [2:0] bitCnt, addrLeft;
		logic [7:0] shift, cmd;
		logic [31:0] addr;
		logic wide, capture, gotData;
		logic [3:0] pageIdx;
		logic [15:0][7:0] pageBuf;
		logic [15:0] pageMask;
		eng_type eng;
		op_type op, eraseOp;
		logic [31:0] remain, elapsed, eraseRemain, eraseElapsed, progRemain, eraseLimit;
		logic [15:0] suspCnt, protect;
		logic [7:0] opAddr, eraseAddr, progAddr, fs;
		logic eraseSusp, progSusp, wel, addr4, nvAddr4;
		logic [255:0][7:0] array;
		logic awHeld, wHeld, bvalid, rvalid;
		logic [11:0] awAddr;
		logic [31:0] wData, rdata;
		logic [3:0] wStrb;
		logic [1:0] bresp, rresp;
	} state_type;

endpackage

// ---- rtl/flash_program_erase_suspend_sequencer.sv ----
// Serial NOR flash program/erase/suspend sequencer with a 256-byte array model.
// Assumes the link pins come from another clock domain and an AXI4-Lite master.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_defines.svh"

module flash_program_erase_suspend_sequencer #(
	parameter logic [31:0] PAGE_PROGRAM_CYCLES    = `CYCLES_UP(`PAGE_PROGRAM_TIME_NS),
	parameter logic [31:0] SUBSECTOR_ERASE_CYCLES = `CYCLES_UP(`SUBSECTOR_ERASE_TIME_NS),
	parameter logic [31:0] SECTOR_ERASE_CYCLES    = `CYCLES_UP(`SECTOR_ERASE_TIME_NS),
	parameter logic [31:0] BULK_ERASE_CYCLES      = `CYCLES_UP(`BULK_ERASE_TIME_NS)
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        chipSelectN,
	input  wire logic        serialClk,
	input  wire logic [3:0]  serial_io_lines,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);

	flash_seq_pkg::state_type q, d;

	function automatic logic isProgram(input logic [7:0] c);
		return c == `OPC_PAGE_PROGRAM || c == `OPC_QUAD_PROGRAM || c == `OPC_QUAD_PROGRAM_A4;
	endfunction

	function automatic logic isErase(input logic [7:0] c);
		return c == `OPC_SUBSECTOR_ERASE || c == `OPC_SUBSECTOR_ERASE_ALT
			|| c == `OPC_SECTOR_ERASE || c == `OPC_BULK_ERASE || c == `OPC_BULK_ERASE_ALT;
	endfunction

	function automatic flash_seq_pkg::op_type eraseKind(input logic [7:0] c);
		if (c == `OPC_SECTOR_ERASE) begin
			return flash_seq_pkg::OP_ERASE_SEC;
		end else if (c == `OPC_BULK_ERASE || c == `OPC_BULK_ERASE_ALT) begin
			return flash_seq_pkg::OP_ERASE_BULK;
		end
		return flash_seq_pkg::OP_ERASE_SUB;
	endfunction

	function automatic logic [31:0] opCycles(input flash_seq_pkg::op_type k);
		unique case (k)
			flash_seq_pkg::OP_PROGRAM:   return PAGE_PROGRAM_CYCLES;
			flash_seq_pkg::OP_ERASE_SUB: return SUBSECTOR_ERASE_CYCLES;
			flash_seq_pkg::OP_ERASE_SEC: return SECTOR_ERASE_CYCLES;
			default:                     return BULK_ERASE_CYCLES;
		endcase
	endfunction

	// Sector covers four subsectors; bulk checks every protection bit
	function automatic logic protHit(input flash_seq_pkg::op_type k, input logic [7:0] a,
			input logic [15:0] prot);
		logic [15:0] secMask;
		secMask = 16'h000f << {a[7:6], 2'b00};
		unique case (k)
			flash_seq_pkg::OP_ERASE_SEC:  return |(prot & secMask);
			flash_seq_pkg::OP_ERASE_BULK: return |prot;
			default:                      return prot[a[7:4]];
		endcase
	endfunction

	function automatic logic inRegion(input flash_seq_pkg::op_type k, input logic [7:0] a,
			input logic [7:0] j);
		unique case (k)
			flash_seq_pkg::OP_ERASE_SEC:  return j[7:6] == a[7:6];
			flash_seq_pkg::OP_ERASE_BULK: return 1'b1;
			default:                      return j[7:4] == a[7:4];
		endcase
	endfunction

	logic sclkRise, csRise, frameOk, exec, idle, opDone, eraseAbort, execErase;
	logic [31:0] elapsedNext;

	// Only the second and third sync stages feed logic
	assign sclkRise    = q.sclk2 & ~q.sclk3;
	assign csRise      = q.cs2 & ~q.cs3;
	assign frameOk     = q.phase == flash_seq_pkg::PH_DATA && q.bitCnt == 3'h0
		&& (!isProgram(q.cmd) || q.gotData);
	assign exec        = csRise && frameOk;
	assign idle        = q.eng == flash_seq_pkg::ENG_IDLE;
	assign elapsedNext = q.elapsed + 32'h1;
	assign opDone      = !idle && q.remain == 32'h1;
	assign eraseAbort  = !idle && q.op != flash_seq_pkg::OP_PROGRAM && !opDone
		&& elapsedNext >= q.eraseLimit;
	assign execErase   = exec && idle && isErase(q.cmd);

	assign awready = !q.awHeld && !q.bvalid;
	assign wready  = !q.wHeld && !q.bvalid;
	assign arready = !q.rvalid;
	assign bvalid  = q.bvalid;
	assign bresp   = q.bresp;
	assign rvalid  = q.rvalid;
	assign rdata   = q.rdata;
	assign rresp   = q.rresp;

	always_comb begin
		logic [7:0] nb;
		logic [7:0] idx;
		nb = 8'h00;
		idx = 8'h00;
		d = q;
		d.cs1 = chipSelectN;
		d.cs2 = q.cs1;
		d.cs3 = q.cs2;
		d.sclk1 = serialClk;
		d.sclk2 = q.sclk1;
		d.sclk3 = q.sclk2;
		d.io1 = serial_io_lines;
		d.io2 = q.io1;

		// Link side: shift bits on each sampled rising edge of the serial clock
		if (q.cs2) begin
			d.phase = flash_seq_pkg::PH_CMD;
			d.bitCnt = 3'h0;
			d.gotData = 1'b0;
		end else if (sclkRise) begin
			if (q.phase == flash_seq_pkg::PH_DATA && q.wide) begin
				nb = {q.shift[3:0], q.io2};
				d.bitCnt = q.bitCnt + 3'h4;
			end else begin
				nb = {q.shift[6:0], q.io2[0]};
				d.bitCnt = q.bitCnt + 3'h1;
			end
			d.shift = nb;
			if (d.bitCnt == 3'h0) begin
				unique case (q.phase)
					flash_seq_pkg::PH_CMD: begin
						d.cmd = nb;
						d.wide = nb == `OPC_QUAD_PROGRAM || nb == `OPC_QUAD_PROGRAM_A4;
						// A suspended program keeps its page buffer untouched
						d.capture = isProgram(nb) && idle && !q.progSusp;
						if (d.capture) begin
							d.pageMask = 16'h0000;
						end
						if (isProgram(nb) || eraseKind(nb) != flash_seq_pkg::OP_ERASE_BULK
								&& isErase(nb)) begin
							d.phase = flash_seq_pkg::PH_ADDR;
							d.addrLeft = (nb == `OPC_QUAD_PROGRAM_A4 || q.addr4) ?
								`ADDR_BYTES_4 : `ADDR_BYTES_3;
						end else begin
							d.phase = flash_seq_pkg::PH_DATA;
						end
					end
					flash_seq_pkg::PH_ADDR: begin
						d.addr = {q.addr[23:0], nb};
						d.addrLeft = q.addrLeft - 3'h1;
						if (q.addrLeft == 3'h1) begin
							d.phase = flash_seq_pkg::PH_DATA;
							d.pageIdx = nb[3:0];
						end
					end
					default: begin
						d.gotData = 1'b1;
						if (q.capture) begin
							// Data past the page end wraps to the page start
							d.pageBuf[q.pageIdx] = nb;
							d.pageMask[q.pageIdx] = 1'b1;
							d.pageIdx = q.pageIdx + 4'h1;
						end
					end
				endcase
			end
		end

		// Command execution at a byte-aligned frame end; anything else is dropped
		if (exec) begin
			if (q.cmd == `OPC_CLEAR_FLAGS) begin
				d.fs[`FS_PROT_ERR] = 1'b0;
				d.fs[`FS_PROG_ERR] = 1'b0;
				d.fs[`FS_ERASE_ERR] = 1'b0;
			end else if (q.cmd == `OPC_SUSPEND && q.eng == flash_seq_pkg::ENG_RUN) begin
				d.eng = flash_seq_pkg::ENG_SUSPENDING;
				d.suspCnt = `SUSPEND_LATENCY_CYCLES;
				if (q.op == flash_seq_pkg::OP_PROGRAM) begin
					d.fs[`FS_PROG_SUSP] = 1'b1;
				end else begin
					d.fs[`FS_ERASE_SUSP] = 1'b1;
				end
			end else if (idle) begin
				if (q.cmd == `OPC_WRITE_ENABLE) begin
					d.wel = 1'b1;
				end else if (q.cmd == `OPC_WRITE_DISABLE) begin
					d.wel = 1'b0;
				end else if (q.cmd == `OPC_ENTER_ADDR4) begin
					d.addr4 = 1'b1;
				end else if (q.cmd == `OPC_EXIT_ADDR4) begin
					d.addr4 = 1'b0;
				end else if (isErase(q.cmd)) begin
					if (q.wel && !q.eraseSusp && !q.progSusp) begin
						if (protHit(eraseKind(q.cmd), q.addr[7:0], q.protect)) begin
							d.fs[`FS_PROT_ERR] = 1'b1;
							d.fs[`FS_ERASE_ERR] = 1'b1;
						end else begin
							d.eng = flash_seq_pkg::ENG_RUN;
							d.op = eraseKind(q.cmd);
							d.remain = opCycles(eraseKind(q.cmd));
							d.elapsed = 32'h0;
							d.opAddr = q.addr[7:0];
							d.fs[`FS_READY] = 1'b0;
						end
					end
				end else if (isProgram(q.cmd)) begin
					if (q.wel && !q.progSusp && q.capture) begin
						if (q.eraseSusp && q.addr[7:6] == q.eraseAddr[7:6]) begin
							d.fs[`FS_PROG_ERR] = 1'b1;
						end else if (protHit(flash_seq_pkg::OP_PROGRAM, q.addr[7:0],
								q.protect)) begin
							d.fs[`FS_PROT_ERR] = 1'b1;
							d.fs[`FS_PROG_ERR] = 1'b1;
						end else begin
							d.eng = flash_seq_pkg::ENG_RUN;
							d.op = flash_seq_pkg::OP_PROGRAM;
							d.remain = opCycles(flash_seq_pkg::OP_PROGRAM);
							d.elapsed = 32'h0;
							d.opAddr = q.addr[7:0];
							d.fs[`FS_READY] = 1'b0;
						end
					end
				end else if (q.cmd == `OPC_RESUME) begin
					// Inner (program) level always resumes before the erase
					if (q.progSusp) begin
						d.eng = flash_seq_pkg::ENG_RUN;
						d.op = flash_seq_pkg::OP_PROGRAM;
						d.remain = q.progRemain;
						d.opAddr = q.progAddr;
						d.progSusp = 1'b0;
						d.fs[`FS_PROG_SUSP] = 1'b0;
						d.fs[`FS_READY] = 1'b0;
					end else if (q.eraseSusp) begin
						d.eng = flash_seq_pkg::ENG_RUN;
						d.op = q.eraseOp;
						d.remain = q.eraseRemain;
						d.elapsed = q.eraseElapsed;
						d.opAddr = q.eraseAddr;
						d.eraseSusp = 1'b0;
						d.fs[`FS_ERASE_SUSP] = 1'b0;
						d.fs[`FS_READY] = 1'b0;
					end
				end
			end
		end

		// Engine: counts down on the system clock, no link clock needed
		if (!idle) begin
			d.remain = q.remain - 32'h1;
			d.elapsed = elapsedNext;
			if (q.eng == flash_seq_pkg::ENG_SUSPENDING) begin
				d.suspCnt = q.suspCnt - 16'h1;
			end
			if (opDone) begin
				if (q.op == flash_seq_pkg::OP_PROGRAM) begin
					for (int i = 0; i < 16; i++) begin
						idx = {q.opAddr[7:4], 4'(i)};
						if (q.pageMask[i]) begin
							d.array[idx] = q.array[idx] & q.pageBuf[i];
						end
					end
					d.fs[`FS_PROG_SUSP] = 1'b0;
				end else begin
					for (int j = 0; j < 256; j++) begin
						if (inRegion(q.op, q.opAddr, 8'(j))) begin
							d.array[j] = 8'hff;
						end
					end
					d.fs[`FS_ERASE_SUSP] = 1'b0;
				end
				d.eng = flash_seq_pkg::ENG_IDLE;
				d.wel = 1'b0;
				d.fs[`FS_READY] = 1'b1;
			end else if (eraseAbort) begin
				d.eng = flash_seq_pkg::ENG_IDLE;
				d.wel = 1'b0;
				d.fs[`FS_ERASE_ERR] = 1'b1;
				d.fs[`FS_ERASE_SUSP] = 1'b0;
				d.fs[`FS_READY] = 1'b1;
			end else if (q.eng == flash_seq_pkg::ENG_SUSPENDING && q.suspCnt == 16'h1) begin
				if (q.op == flash_seq_pkg::OP_PROGRAM) begin
					d.progSusp = 1'b1;
					d.progRemain = q.remain - 32'h1;
					d.progAddr = q.opAddr;
				end else begin
					d.eraseSusp = 1'b1;
					d.eraseOp = q.op;
					d.eraseRemain = q.remain - 32'h1;
					d.eraseElapsed = elapsedNext;
					d.eraseAddr = q.opAddr;
				end
				d.eng = flash_seq_pkg::ENG_IDLE;
				d.fs[`FS_READY] = 1'b1;
			end
		end

		// AXI4-Lite slave; address and data may arrive in either order
		if (awvalid && awready) begin
			d.awHeld = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			d.wHeld = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (q.awHeld && q.wHeld) begin
			d.awHeld = 1'b0;
			d.wHeld = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RESP_OKAY;
			if (q.awAddr[11:2] == `REG_CONFIG >> 2) begin
				if (q.wStrb[0]) begin
					d.nvAddr4 = q.wData[0];
					d.addr4 = q.wData[0];
				end
			end else if (q.awAddr[11:2] == `REG_PROTECT >> 2) begin
				for (int b = 0; b < 2; b++) begin
					if (q.wStrb[b]) begin
						d.protect[8 * b +: 8] = q.wData[8 * b +: 8];
					end
				end
			end else if (q.awAddr[11:2] == `REG_ERASE_LIMIT >> 2) begin
				for (int b = 0; b < 4; b++) begin
					if (q.wStrb[b]) begin
						d.eraseLimit[8 * b +: 8] = q.wData[8 * b +: 8];
					end
				end
			end else if (q.awAddr[11:2] != `REG_STATUS >> 2
					&& q.awAddr[11:8] != `REG_ARRAY_PAGE) begin
				d.bresp = `RESP_SLVERR;
			end
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			d.rvalid = 1'b1;
			d.rresp = `RESP_OKAY;
			d.rdata = 32'h0;
			if (araddr[11:8] == `REG_ARRAY_PAGE) begin
				for (int b = 0; b < 4; b++) begin
					d.rdata[8 * b +: 8] = q.array[{araddr[7:2], 2'(b)}];
				end
			end else if (araddr[11:2] == `REG_CONFIG >> 2) begin
				d.rdata[0] = q.nvAddr4;
			end else if (araddr[11:2] == `REG_PROTECT >> 2) begin
				d.rdata[15:0] = q.protect;
			end else if (araddr[11:2] == `REG_ERASE_LIMIT >> 2) begin
				d.rdata = q.eraseLimit;
			end else if (araddr[11:2] == `REG_STATUS >> 2) begin
				d.rdata[0] = !idle;
				d.rdata[1] = q.wel;
				d.rdata[15:8] = {q.fs[7:1], q.addr4};
			end else begin
				d.rresp = `RESP_SLVERR;
			end
		end else if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
			q.cs1 <= 1'b1;
			q.cs2 <= 1'b1;
			q.cs3 <= 1'b1;
			q.fs <= `FS_RESET;
			q.eraseLimit <= `ERASE_LIMIT_RST;
			q.array <= '1;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence suspendTaken;
		exec && q.cmd == `OPC_SUSPEND && q.eng == flash_seq_pkg::ENG_RUN && !opDone
			&& !eraseAbort;
	endsequence
	sequence parking;
		q.eng == flash_seq_pkg::ENG_SUSPENDING && q.suspCnt == 16'h1 && !opDone && !eraseAbort;
	endsequence

	a_erase_needs_wel: assert property (execErase && !q.wel |=> idle && q.fs == $past(q.fs))
		else $error("erase started without write enable");
	a_erase_protect: assert property (execErase && q.wel && !q.eraseSusp && !q.progSusp
		&& protHit(eraseKind(q.cmd), q.addr[7:0], q.protect)
		|=> q.fs[`FS_PROT_ERR] && q.fs[`FS_ERASE_ERR] && q.wel && idle)
		else $error("protected erase not refused");
	a_erase_busy: assert property (q.eng == flash_seq_pkg::ENG_RUN
		&& q.op != flash_seq_pkg::OP_PROGRAM |-> !q.fs[`FS_READY])
		else $error("ready flag set during erase");
	a_end_wel: assert property (opDone |=> !q.wel && idle && q.fs[`FS_READY])
		else $error("latch not cleared at end");
	a_erase_timeout: assert property (eraseAbort |=> q.fs[`FS_ERASE_ERR] && !q.wel)
		else $error("timeout not flagged");
	a_suspend_flag: assert property (suspendTaken |=> q.eng == flash_seq_pkg::ENG_SUSPENDING
		&& (q.fs[`FS_PROG_SUSP] || q.fs[`FS_ERASE_SUSP]))
		else $error("suspend flag missing");
	a_suspend_ready: assert property (parking |=> idle && q.fs[`FS_READY]
		&& (q.progSusp || q.eraseSusp))
		else $error("suspend did not park");
	a_short_finish: assert property (opDone && q.eng == flash_seq_pkg::ENG_SUSPENDING
		&& q.op == flash_seq_pkg::OP_PROGRAM |=> !q.fs[`FS_PROG_SUSP])
		else $error("suspend flag left after finish");
	a_resume_ignored: assert property (exec && idle && q.cmd == `OPC_RESUME && !q.progSusp
		&& !q.eraseSusp |=> idle)
		else $error("resume ran with nothing suspended");
	a_nest_order: assert property (exec && idle && q.cmd == `OPC_RESUME && q.progSusp
		&& q.eraseSusp |=> q.op == flash_seq_pkg::OP_PROGRAM && q.eraseSusp)
		else $error("wrong resume order");
	a_frame_discard: assert property (csRise && !frameOk && !opDone && !eraseAbort
		|=> q.wel == $past(q.wel))
		else $error("unaligned frame had effect");
	a_erase_ones: assert property (opDone && q.op == flash_seq_pkg::OP_ERASE_SUB
		|=> q.array[$past(q.opAddr)] == 8'hff)
		else $error("erased byte not all ones");
	a_program_clear: assert property (opDone && q.op == flash_seq_pkg::OP_PROGRAM
		|=> (q.array & ~$past(q.array)) == '0)
		else $error("program set a bit");
	a_addr_four: assert property ($rose(q.phase == flash_seq_pkg::PH_ADDR)
		&& q.cmd == `OPC_QUAD_PROGRAM_A4 |-> q.addrLeft == `ADDR_BYTES_4)
		else $error("4-byte opcode took short address");

endmodule
`default_nettype wire

// ---- verification/flash_host_model.sv ----
// Host serial flash controller model: drives chip select, link clock and data lines.
// Assumes the bench calls frame() and leaves at least one frame gap between calls.
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
	output logic       chipSelectN,
	output logic       serialClk,
	output logic [3:0] ioLines
);
	initial begin
		chipSelectN = 1'b1;
		serialClk   = 1'b0;
		ioLines     = 4'h5;
	end
	// Clock stands low between frames; released lines show the inverse of their last value
	task automatic frame(input logic [63:0] d, input int nb, input logic [7:0] qd, input int nq);
		#13 chipSelectN = 1'b0;
		for (int i = 0; i < nb; i++) begin
			ioLines[0] = d[63 - i];
			#200 serialClk = 1'b1;
			#200 serialClk = 1'b0;
		end
		for (int i = 0; i < nq; i++) begin
			ioLines = i[0] ? qd[3:0] : qd[7:4];
			#200 serialClk = 1'b1;
			#200 serialClk = 1'b0;
		end
		// Chip select rises only after the last whole unit, unless nb is cut short on purpose
		#200 chipSelectN = 1'b1;
		ioLines = ~ioLines;
		#600;
	endtask
endmodule
`default_nettype wire

// ---- verification/test_flash_program_erase_suspend_sequencer.sv ----
// Self-checking bench for the flash sequencer: AXI4-Lite master plus host link model.
// Assumes shortened program and erase counts; suspend latency stays at its full value.
`timescale 1ns/10ps
`default_nettype none
module test_flash_program_erase_suspend_sequencer;
	logic        clk_sys, rst_n, chipSelectN, serialClk;
	logic [3:0]  ioLines, wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rr, br;
	int          failCount, checkCount;
	localparam logic [63:0] WREN = 64'h06 << 56;
	localparam logic [11:0] STAT = 12'h00c;

	flash_program_erase_suspend_sequencer #(.PAGE_PROGRAM_CYCLES(32'd800),
		.SUBSECTOR_ERASE_CYCLES(32'd2000), .SECTOR_ERASE_CYCLES(32'd2400),
		.BULK_ERASE_CYCLES(32'd2600)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.chipSelectN(chipSelectN), .serialClk(serialClk), .serial_io_lines(ioLines),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	flash_host_model host_u (.chipSelectN(chipSelectN), .serialClk(serialClk), .ioLines(ioLines));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic timeout;
		failCount++;
		$display("wrong value at %0t: wait ran out", $time);
		close_out();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				br = bresp;
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic axiRead(input logic [11:0] a);
		@(posedge clk_sys);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd = rdata;
				rr = rresp;
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic cmd(input logic [63:0] d, input int nb);
		host_u.frame(d, nb, 8'h00, 0);
	endtask

	task automatic waitReady;
		for (int n = 0; n < 2000; n++) begin
			axiRead(STAT);
			if (rd[15] === 1'b1) return;
		end
		timeout();
	endtask

	task automatic statusIs(input logic [31:0] m, input logic [31:0] e);
		axiRead(STAT);
		chk(rd & m, e);
	endtask

	task automatic resetAndMap;
		statusIs(32'hffffffff, 32'h00008000);
		axiRead(12'h040);
		chk({30'h0, rr}, 32'h2);
		chk(rd, 32'h0);
		cmd(64'h20000010 << 32, 32);
		statusIs(32'hffffffff, 32'h00008000);
		axiWrite(12'h040, 32'h0);
		chk({30'h0, br}, 32'h2);
		axiWrite(12'h000, 32'h1);
		chk({30'h0, br}, 32'h0);
		axiRead(12'h000);
		chk(rd, 32'h1);
		statusIs(32'hffffffff, 32'h00008100);
		axiWrite(12'h000, 32'h0);
		cmd(64'hb7 << 56, 8);
		statusIs(32'hffffffff, 32'h00008100);
		// Plain program opcode takes four address bytes once the mode is entered
		cmd(WREN, 8);
		cmd({40'h0200000030, 8'ha5, 16'h0}, 48);
		waitReady();
		axiRead(12'h130);
		chk(rd, 32'hffffffa5);
		cmd(64'he9 << 56, 8);
		statusIs(32'hffffffff, 32'h00008000);
	endtask

	task automatic programAndErase;
		cmd(WREN, 8);
		host_u.frame(64'h02000010 << 32, 32, 8'h5a, 0);
		statusIs(32'hffffffff, 32'h00008002);
		cmd({32'h02000010, 8'h5a, 24'h0}, 40);
		waitReady();
		cmd(WREN, 8);
		cmd({32'h02000010, 8'hf0, 24'h0}, 40);
		waitReady();
		axiRead(12'h110);
		chk(rd, 32'hffffff50);
		cmd(WREN, 8);
		cmd(64'h20000010 << 32, 23);
		statusIs(32'hffffffff, 32'h00008002);
		cmd(64'h20000010 << 32, 32);
		statusIs(32'h00008001, 32'h00000001);
		waitReady();
		statusIs(32'hffffffff, 32'h00008000);
		axiRead(12'h110);
		chk(rd, 32'hffffffff);
	endtask

	task automatic protectAndTimeout;
		axiWrite(12'h004, 32'h2);
		cmd(WREN, 8);
		cmd(64'h20000015 << 32, 32);
		statusIs(32'hffffffff, 32'h0000a202);
		cmd(64'h50 << 56, 8);
		cmd(64'hc7 << 56, 8);
		statusIs(32'hffffffff, 32'h0000a202);
		cmd(64'h50 << 56, 8);
		axiWrite(12'h004, 32'h0);
		axiWrite(12'h008, 32'd10);
		cmd(64'h20000000 << 32, 32);
		waitReady();
		statusIs(32'hffffffff, 32'h0000a000);
		cmd(64'h50 << 56, 8);
		axiWrite(12'h008, 32'hffffffff);
		cmd(WREN, 8);
		host_u.frame(64'h3400000020 << 24, 40, 8'h3c, 2);
		waitReady();
		axiRead(12'h120);
		chk(rd, 32'hffffff3c);
	endtask

	task automatic suspendResume;
		cmd(WREN, 8);
		cmd(64'hd8000040 << 32, 32);
		cmd(64'h75 << 56, 8);
		waitReady();
		statusIs(32'h0000c001, 32'h0000c000);
		cmd(WREN, 8);
		cmd({32'h02000044, 8'h00, 24'h0}, 40);
		statusIs(32'h00001002, 32'h00001002);
		cmd({32'h02000000, 8'h00, 24'h0}, 40);
		cmd(64'h75 << 56, 8);
		waitReady();
		statusIs(32'h0000c401, 32'h0000c400);
		axiRead(12'h100);
		chk(rd, 32'hffffffff);
		cmd(64'h7a << 56, 8);
		statusIs(32'h0000c401, 32'h00004001);
		waitReady();
		axiRead(12'h100);
		chk(rd, 32'hffffff00);
		statusIs(32'h00004001, 32'h00004000);
		cmd(64'h7a << 56, 8);
		statusIs(32'h00008001, 32'h00000001);
		waitReady();
		statusIs(32'h00004001, 32'h0);
		cmd(64'h7a << 56, 8);
		statusIs(32'h00008001, 32'h00008000);
		// Suspend late in a program: the remainder is below the latency, so it finishes
		cmd(WREN, 8);
		cmd({32'h02000004, 8'h0f, 24'h0}, 40);
		repeat (320) @(posedge clk_sys);
		cmd(64'h75 << 56, 8);
		statusIs(32'h00000401, 32'h00000401);
		waitReady();
		statusIs(32'h00008401, 32'h00008000);
		axiRead(12'h104);
		chk(rd, 32'hffffff0f);
	endtask

	task automatic powerCycle;
		cmd(WREN, 8);
		cmd(64'hd8000080 << 32, 32);
		cmd(64'h75 << 56, 8);
		waitReady();
		statusIs(32'h00004000, 32'h00004000);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		statusIs(32'hffffffff, 32'h00008000);
		cmd(64'h7a << 56, 8);
		statusIs(32'h00008001, 32'h00008000);
	endtask

	initial begin
		failCount  = 0;
		checkCount = 0;
		rst_n   = 1'b0;
		awvalid = 1'b0;
		awaddr  = 12'h000;
		wvalid  = 1'b0;
		wdata   = 32'h0;
		wstrb   = 4'hf;
		bready  = 1'b0;
		arvalid = 1'b0;
		araddr  = 12'h000;
		rready  = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		resetAndMap();
		programAndErase();
		protectAndTimeout();
		suspendResume();
		powerCycle();
		close_out();
	end
endmodule
`default_nettype wire
